// [gli_pkg.sv]
package gli_pkg;

	// Pin positions of the three indicator functions.
	localparam int GLI_PIN_COUNT = 3;
	localparam int GLI_PIN_SPEED = 0;
	localparam int GLI_PIN_LINKACT = 1;
	localparam int GLI_PIN_DUPLEX = 2;

	// Blink timing: the off pulse and the least on time, in milliseconds.
	localparam int GLI_BLINK_MS = 80;
	localparam int GLI_CLK_KHZ = 250000;
	localparam int GLI_BLINK_CYCLES = GLI_BLINK_MS * GLI_CLK_KHZ;

	// Reset values of the registered pin outputs.
	localparam logic [GLI_PIN_COUNT-1:0] GLI_RST_PINS = 3'h0;

	// Configuration of one pin.
	typedef struct packed {
		logic led_en;     // Pin carries its status indicator.
		logic out_en;     // Pin is a general-purpose output.
		logic open_drain; // Output drives low only.
		logic data;       // Output level.
	} gli_pin_cfg_t;

	// Link status from the integrated PHY and MAC.
	typedef struct packed {
		logic link_up;
		logic autoneg_busy;
		logic speed_100;
		logic full_duplex;
		logic tx_act;
		logic rx_act;
	} gli_phy_status_t;

	// Link-and-activity blink states, Gray coded from GLI_LA_IDLE to GLI_LA_OFF to GLI_LA_MIN_ON; the return to idle changes both bits.
	typedef enum logic [1:0] {
		GLI_LA_IDLE = 2'h0,
		GLI_LA_OFF = 2'h1,
		GLI_LA_MIN_ON = 2'h3
	} gli_la_state_t;

endpackage

// [gli_gpio_led.sv]
`timescale 1ns/1ps

module gli_gpio_led
	import gli_pkg::*;
#(
	parameter int BLINK_CYCLES = GLI_BLINK_CYCLES
)
(
	input wire logic core_clk_i, // System clock, 250 MHz.
	input wire logic resetn_i, // Asynchronous reset, active low.
	input wire gli_pin_cfg_t [GLI_PIN_COUNT-1:0] pin_cfg_i, // Per-pin configuration.
	input wire gli_phy_status_t phy_status_i, // Link status, same clock.
	input wire logic [GLI_PIN_COUNT-1:0] pin_i, // Pad input levels.
	output logic [GLI_PIN_COUNT-1:0] pin_o, // Pad output levels.
	output logic [GLI_PIN_COUNT-1:0] pin_oe_o, // Pad output enables, high drives.
	output logic [GLI_PIN_COUNT-1:0] gpio_in_o // Synchronised pad levels.
);

	// The counter is wide enough for a full interval; its last count ends the interval.
	localparam int CNT_W = $clog2(BLINK_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BLINK_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	logic [GLI_PIN_COUNT-1:0] sync1_ff;
	logic [GLI_PIN_COUNT-1:0] sync2_ff;
	gli_la_state_t la_state_ff;
	gli_la_state_t nxt_la_state;
	logic [CNT_W-1:0] la_cnt_ff;
	logic act_pend_ff;
	logic activity;
	logic start_off;
	logic [GLI_PIN_COUNT-1:0] led_level;
	logic [GLI_PIN_COUNT-1:0] nxt_pin;
	logic [GLI_PIN_COUNT-1:0] nxt_oe;

	// Two-stage synchroniser for the pad inputs.
	// Only the second stage is read, so a metastable first stage never reaches logic.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sync1_ff <= GLI_RST_PINS;
			sync2_ff <= GLI_RST_PINS;
		end
		else
		begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
		end
	end

	// Synchronised levels are presented from a register.
	assign gpio_in_o = sync2_ff;

	// Activity and the start of an off pulse.
	assign activity = phy_status_i.tx_act | phy_status_i.rx_act;
	assign start_off = (la_state_ff == GLI_LA_IDLE) && phy_status_i.link_up &&
		(activity || act_pend_ff);

	// Pending activity: a new event during a pulse wins over the clear on link loss.
	// Holding the event lets a short burst inside a pulse show up as the next pulse.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			act_pend_ff <= 1'b0;
		else if (activity && (la_state_ff != GLI_LA_IDLE))
			act_pend_ff <= 1'b1;
		else if (start_off || !phy_status_i.link_up)
			act_pend_ff <= 1'b0;
	end

	// Next blink state.
	// Losing the link aborts a pulse, so the lamp follows the link at once.
	always_comb
	begin
		nxt_la_state = la_state_ff;
		if (!phy_status_i.link_up)
			nxt_la_state = GLI_LA_IDLE;
		else
		begin
			unique case (la_state_ff)
				GLI_LA_IDLE:
					if (start_off)
						nxt_la_state = GLI_LA_OFF;
				GLI_LA_OFF:
					if (la_cnt_ff == CNT_LAST)
						nxt_la_state = GLI_LA_MIN_ON;
				GLI_LA_MIN_ON:
					if (la_cnt_ff == CNT_LAST)
						nxt_la_state = GLI_LA_IDLE;
				default:
					nxt_la_state = GLI_LA_IDLE;
			endcase
		end
	end

	// Blink state register.
	// The state moves on activity, on the interval counter or on the link status.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			la_state_ff <= GLI_LA_IDLE;
		else
			la_state_ff <= nxt_la_state;
	end

	// Interval counter, restarted on every state change.
	// Both intervals share this counter, which rests at zero while idle.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			la_cnt_ff <= CNT_ZERO;
		else if (nxt_la_state != la_state_ff || la_state_ff == GLI_LA_IDLE)
			la_cnt_ff <= CNT_ZERO;
		else
			la_cnt_ff <= la_cnt_ff + 1'b1;
	end

	// Indicator levels, low meaning LED on.
	// The levels are combinational; the pads show them one cycle later.
	always_comb
	begin
		led_level[GLI_PIN_SPEED] = !(phy_status_i.link_up && !phy_status_i.autoneg_busy &&
			phy_status_i.speed_100);
		led_level[GLI_PIN_LINKACT] = !(phy_status_i.link_up &&
			(la_state_ff != GLI_LA_OFF));
		led_level[GLI_PIN_DUPLEX] = !(phy_status_i.link_up &&
			phy_status_i.full_duplex);
	end

	// Pad drive for each pin from its mode.
	// An indicator only ever pulls low, so a released pin reads high through its pull-up.
	always_comb
	begin
		for (int i = 0; i < GLI_PIN_COUNT; i++)
		begin
			if (pin_cfg_i[i].led_en)
			begin
				nxt_pin[i] = 1'b0;
				nxt_oe[i] = !led_level[i];
			end
			else if (!pin_cfg_i[i].out_en)
			begin
				nxt_pin[i] = 1'b0;
				nxt_oe[i] = 1'b0;
			end
			else if (pin_cfg_i[i].open_drain)
			begin
				nxt_pin[i] = 1'b0;
				nxt_oe[i] = !pin_cfg_i[i].data;
			end
			else
			begin
				nxt_pin[i] = pin_cfg_i[i].data;
				nxt_oe[i] = 1'b1;
			end
		end
	end

	// Registered pad outputs.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_o <= GLI_RST_PINS;
			pin_oe_o <= GLI_RST_PINS;
		end
		else
		begin
			pin_o <= nxt_pin;
			pin_oe_o <= nxt_oe;
		end
	end

	// Checks on pin drive and blink timing.
	// They are switched off while reset is held.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_speed_fast_on: assert property (
		pin_cfg_i[GLI_PIN_SPEED].led_en && phy_status_i.link_up &&
		!phy_status_i.autoneg_busy && phy_status_i.speed_100
		|=> pin_oe_o[GLI_PIN_SPEED] && !pin_o[GLI_PIN_SPEED])
		else $error("speed indicator not low at 100 Mb/s");

	chk_speed_slow_off: assert property (
		pin_cfg_i[GLI_PIN_SPEED].led_en &&
		(!phy_status_i.link_up || phy_status_i.autoneg_busy || !phy_status_i.speed_100)
		|=> !pin_oe_o[GLI_PIN_SPEED])
		else $error("speed indicator not released");

	chk_led_open_drain: assert property (
		pin_cfg_i[GLI_PIN_LINKACT].led_en |=> !pin_o[GLI_PIN_LINKACT])
		else $error("indicator pin driven high");

	chk_gpio_push_pull: assert property (
		!pin_cfg_i[0].led_en && pin_cfg_i[0].out_en && !pin_cfg_i[0].open_drain
		|=> pin_oe_o[0] && (pin_o[0] == $past(pin_cfg_i[0].data)))
		else $error("push-pull output wrong");

	chk_gpio_input_mode: assert property (
		!pin_cfg_i[1].led_en && !pin_cfg_i[1].out_en |=> !pin_oe_o[1])
		else $error("input pin driven");

	chk_duplex_level: assert property (
		pin_cfg_i[GLI_PIN_DUPLEX].led_en
		|=> pin_oe_o[GLI_PIN_DUPLEX] ==
		($past(phy_status_i.link_up) && $past(phy_status_i.full_duplex)))
		else $error("duplex indicator wrong");

	chk_link_solid_on: assert property (
		pin_cfg_i[GLI_PIN_LINKACT].led_en && phy_status_i.link_up &&
		(la_state_ff != GLI_LA_OFF) |=> pin_oe_o[GLI_PIN_LINKACT])
		else $error("link indicator not on");

	chk_off_pulse_len: assert property (
		phy_status_i.link_up && la_state_ff == GLI_LA_OFF && la_cnt_ff != CNT_LAST
		|=> la_state_ff == GLI_LA_OFF)
		else $error("off pulse ended early");

	chk_min_on_len: assert property (
		phy_status_i.link_up && la_state_ff == GLI_LA_MIN_ON && la_cnt_ff != CNT_LAST
		|=> la_state_ff == GLI_LA_MIN_ON)
		else $error("on time ended early");

	chk_off_then_on: assert property (
		phy_status_i.link_up && la_state_ff == GLI_LA_OFF && la_cnt_ff == CNT_LAST
		|=> la_state_ff == GLI_LA_MIN_ON)
		else $error("off pulse not followed by on time");

	chk_blink_repeat: assert property (
		la_state_ff == GLI_LA_IDLE && phy_status_i.link_up && act_pend_ff
		|=> la_state_ff == GLI_LA_OFF)
		else $error("pending activity not blinked");

	chk_activity_latch: assert property (
		activity && la_state_ff != GLI_LA_IDLE |=> act_pend_ff || !$past(phy_status_i.link_up))
		else $error("activity lost during blink");

	// Further checks on mode priority, link loss and the interval counter.
	chk_gpio_open_drain: assert property (
		!pin_cfg_i[2].led_en && pin_cfg_i[2].out_en && pin_cfg_i[2].open_drain
		|=> !pin_o[2] && (pin_oe_o[2] == !$past(pin_cfg_i[2].data)))
		else $error("open-drain output wrong");

	chk_led_mode_wins: assert property (
		pin_cfg_i[0].led_en && pin_cfg_i[0].out_en && !pin_cfg_i[0].open_drain &&
		pin_cfg_i[0].data |=> !pin_o[0])
		else $error("indicator mode did not override the pin mode");

	chk_duplex_drive_low: assert property (
		pin_cfg_i[GLI_PIN_DUPLEX].led_en |=> !pin_o[GLI_PIN_DUPLEX])
		else $error("duplex indicator driven high");

	chk_link_lost_off: assert property (
		pin_cfg_i[GLI_PIN_LINKACT].led_en && !phy_status_i.link_up
		|=> !pin_oe_o[GLI_PIN_LINKACT] && la_state_ff == GLI_LA_IDLE)
		else $error("link indicator lit without link");

	chk_activity_blinks: assert property (
		la_state_ff == GLI_LA_IDLE && phy_status_i.link_up && activity
		|=> la_state_ff == GLI_LA_OFF)
		else $error("activity did not start an off pulse");

	chk_blink_pin_off: assert property (
		pin_cfg_i[GLI_PIN_LINKACT].led_en && la_state_ff == GLI_LA_OFF
		|=> !pin_oe_o[GLI_PIN_LINKACT])
		else $error("link indicator lit during off pulse");

	chk_count_restart: assert property (
		la_state_ff != $past(la_state_ff) |-> la_cnt_ff == CNT_ZERO)
		else $error("interval counter not restarted");

	chk_on_then_idle: assert property (
		phy_status_i.link_up && la_state_ff == GLI_LA_MIN_ON && la_cnt_ff == CNT_LAST
		|=> la_state_ff == GLI_LA_IDLE)
		else $error("on time not followed by idle");

	chk_pending_dropped: assert property (
		!phy_status_i.link_up && la_state_ff == GLI_LA_IDLE |=> !act_pend_ff)
		else $error("pending activity kept without link");

	cov_blink_start: cover property (la_state_ff == GLI_LA_IDLE ##1 la_state_ff == GLI_LA_OFF);
	cov_min_on_reached: cover property (la_state_ff == GLI_LA_OFF ##1 la_state_ff == GLI_LA_MIN_ON);
	cov_back_to_back: cover property (la_state_ff == GLI_LA_MIN_ON ##1
		la_state_ff == GLI_LA_IDLE ##1 la_state_ff == GLI_LA_OFF);
	cov_od_gpio_low: cover property (!pin_cfg_i[2].led_en && pin_cfg_i[2].out_en &&
		pin_cfg_i[2].open_drain && !pin_cfg_i[2].data);
	cov_pending_set: cover property (activity && la_state_ff != GLI_LA_IDLE ##1 act_pend_ff);

endmodule

// [gli_pad_model.sv]
`timescale 1ns/1ps

// Board side of the three pads: pull-ups, and a driver that the bench may enable per pin.
module gli_pad_model
	import gli_pkg::*;
(
	input wire logic [GLI_PIN_COUNT-1:0] pad_out_i, // Level the block puts out.
	input wire logic [GLI_PIN_COUNT-1:0] pad_oe_i, // High while the block drives.
	input wire logic [GLI_PIN_COUNT-1:0] brd_drv_i, // High while the board drives.
	input wire logic [GLI_PIN_COUNT-1:0] brd_val_i, // Level the board drives.
	output logic [GLI_PIN_COUNT-1:0] pad_o // Resolved pad level.
);
	// A released pad without a board driver floats up, so open-drain high reads 1.
	assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (~brd_drv_i | brd_val_i));
endmodule

// [tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
	import gli_pkg::*;
	localparam int BLINK = 8;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	gli_pin_cfg_t [GLI_PIN_COUNT-1:0] pin_cfg = '0;
	gli_phy_status_t phy = '0;
	logic [GLI_PIN_COUNT-1:0] pad, pin_o, pin_oe, gpio_in;
	logic [GLI_PIN_COUNT-1:0] brd_drv = 3'h0;
	logic [GLI_PIN_COUNT-1:0] brd_val = 3'h0;
	logic on, ep;
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 92132;
	int cnt;

	// The clock toggles every 2 ns for 250 MHz.
	always #2 core_clk = ~core_clk;

	gli_gpio_led #(.BLINK_CYCLES(BLINK)) dut_u (.core_clk_i(core_clk), .resetn_i(resetn),
		.pin_cfg_i(pin_cfg), .phy_status_i(phy), .pin_i(pad), .pin_o(pin_o),
		.pin_oe_o(pin_oe), .gpio_in_o(gpio_in));
	gli_pad_model pad_u (.pad_out_i(pin_o), .pad_oe_i(pin_oe), .brd_drv_i(brd_drv),
		.brd_val_i(brd_val), .pad_o(pad));

	// Works out whether an indicator lamp is lit while the blinker is idle.
	function automatic logic ind_on(int p, gli_phy_status_t s);
		if (p == GLI_PIN_SPEED)
			return s.link_up & ~s.autoneg_busy & s.speed_100;
		if (p == GLI_PIN_LINKACT)
			return s.link_up;
		return s.link_up & s.full_duplex;
	endfunction

	// Works out the expected output enable of one pin.
	function automatic logic exp_oe(gli_pin_cfg_t c, logic lit);
		if (c.led_en)
			return lit;
		if (!c.out_en)
			return 1'b0;
		return c.open_drain ? ~c.data : 1'b1;
	endfunction

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Counts cycles of one link lamp state; drops transmit, flags receive once on request.
	task automatic count_run(input logic lvl, input int pulse_at);
		cnt = 0;
		while (pin_oe[GLI_PIN_LINKACT] === lvl && cnt < 40)
		begin
			phy = {phy[5:2], 1'b0, cnt == pulse_at};
			cnt++;
			@(negedge core_clk);
		end
	endtask

	// Cuts a hang short well beyond the expected run time.
	initial
	begin
		#20000;
		n_errors++;
		tally_and_finish();
	end

	// Main sequence.
	initial
	begin
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge core_clk);
			pin_cfg = (i == 0) ? 12'h888 : (i == 1) ? 12'hDDD : 12'($random(seed));
			phy = (i == 0) ? 6'h2C : (i == 1) ? 6'h38 : 6'($random(seed)) & 6'h3C;
			brd_val = 3'($random(seed));
			for (int p = 0; p < GLI_PIN_COUNT; p++)
				brd_drv[p] = ~pin_cfg[p].led_en & ~pin_cfg[p].out_en;
			repeat (3) @(negedge core_clk);
			for (int p = 0; p < GLI_PIN_COUNT; p++)
			begin
				on = ind_on(p, phy);
				ep = pin_cfg[p].led_en ? ~on : pin_cfg[p].out_en ? pin_cfg[p].data : brd_val[p];
				`CHK(pin_oe[p], exp_oe(pin_cfg[p], on))
				`CHK(pad[p], ep)
				`CHK(gpio_in[p], ep)
			end
		end
		$display("test pin modes done");
		@(negedge core_clk);
		pin_cfg = 12'h888;
		brd_drv = 3'h0;
		phy = 6'h22;
		@(negedge core_clk);
		count_run(1'b1, -1);
		count_run(1'b0, 3);
		`CHK(cnt, BLINK)
		count_run(1'b1, -1);
		`CHK(cnt, BLINK + 1)
		count_run(1'b0, -1);
		`CHK(cnt, BLINK)
		repeat (3 * BLINK) @(negedge core_clk);
		`CHK(pin_oe[GLI_PIN_LINKACT], 1'b1)
		phy = 6'h00;
		repeat (2) @(negedge core_clk);
		`CHK(pin_oe[GLI_PIN_LINKACT], 1'b0)
		$display("test blink done");
		tally_and_finish();
	end
endmodule
